// ### rtl/lics_charge_seq.sv
// Charge cycle sequencer with AHB-Lite configuration and status registers
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
module lics_charge_seq #(
	parameter int unsigned TICK_CYCLES = lics_pkg::TICK_CYCLES,
	parameter int unsigned PWM_BITS = 8
) (
	input wire logic hclk, // Timebase clock
	input wire logic hresetn, // Power-on reset
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write access
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Always ready
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data
	input wire logic power_valid, // Supply at valid level
	input wire lics_pkg::lics_cmp_s cmp, // Comparator results
	input wire lics_pkg::lics_tri_s end_current_select, // Sensed pin level
	input wire lics_pkg::lics_tri_s display_choice, // Sensed pin level
	input wire logic [PWM_BITS-1:0] regulation_demand, // Loop duty demand
	output logic switch_drive, // Charge switch control
	output lics_pkg::lics_reg_e reg_mode, // Regulation target
	output lics_pkg::lics_end_e end_current_threshold, // Comparator level
	output logic inrush_guard_n, // Low disconnects capacitor
	output logic [2:0] led_o, // Indicator levels, bit 0 first
	output logic [2:0] led_oe, // Indicator drive enables
	output logic indicator_common_o, // Common return level
	output logic indicator_common_oe // Common return drive enable
);
	function automatic lics_pkg::lics_level_e decode_level(
		lics_pkg::lics_tri_s p);
		if (p.seen_high)
			return lics_pkg::LVL_HIGH;
		else if (p.seen_low)
			return lics_pkg::LVL_LOW;
		else
			return lics_pkg::LVL_FLOAT;
	endfunction

	lics_pkg::lics_state_e state, next_state, ret_state;
	lics_pkg::lics_cmp_s cmp_q;
	lics_pkg::lics_level_e disp_mode;
	logic pv_q, present, present_prev, insert, lost;
	logic [16:0] tick_cnt;
	logic ms_tick, sec_tick, flash, cycle_run;
	logic [9:0] ms_in_s;
	logic [5:0] flash_cnt;
	logic [15:0] phase_ms, blank_ms, qual_s, total_s, max_time_s, qual_to_s;
	logic [7:0] low_ms;
	logic holdoff_done, term_done, blank_done, cv_phase;
	logic [PWM_BITS-1:0] pwm_cnt;
	logic [2:0] next_led;
	logic ap_valid, wr_pend;
	logic [7:0] wr_addr;

	//////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, read data loaded at the address phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ap_valid = hsel & htrans[1] & hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= ap_valid & hwrite;
			wr_addr <= haddr[7:0];
			if (ap_valid && !hwrite) begin
				case (haddr[7:0])
				lics_pkg::CONFIG_ADDR: begin
					hrdata <= {qual_to_s, max_time_s};
				end
				lics_pkg::STATUS_ADDR: begin
					hrdata <= 32'h0000_0000;
					hrdata[lics_pkg::STAT_STATE_LSB +: 7] <= state;
					hrdata[lics_pkg::STAT_MODE_LSB +: 2] <= disp_mode;
					hrdata[lics_pkg::STAT_ENDSEL_LSB +: 2] <= end_current_threshold;
					hrdata[lics_pkg::STAT_CV_LSB] <= cv_phase;
					hrdata[lics_pkg::STAT_PRESENT_LSB] <= present;
				end
				default: begin
					hrdata <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			max_time_s <= lics_pkg::MAX_TIME_RESET;
			qual_to_s <= lics_pkg::QUAL_TO_RESET;
		end else if (wr_pend && wr_addr == lics_pkg::CONFIG_ADDR) begin
			max_time_s <= hwdata[lics_pkg::MAX_TIME_LSB +: 16];
			qual_to_s <= hwdata[lics_pkg::QUAL_TO_LSB +: 16];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Input registering and battery presence window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_q <= '0;
			pv_q <= 1'b0;
			present_prev <= 1'b0;
		end else begin
			cmp_q <= cmp;
			pv_q <= power_valid;
			present_prev <= present;
		end
	end

	assign present = cmp_q.above_low & ~cmp_q.above_high;
	assign insert = present & ~present_prev;
	// High cutoff is masked during holdoff of qualify and fast phases
	assign lost = ~cmp_q.above_low | (cmp_q.above_high &
		~(((state == lics_pkg::ST_QUAL) || (state == lics_pkg::ST_FAST)) &&
		!holdoff_done));

	//////////////////////////////////////////////////////////////////////////
	// Millisecond and second ticks, flash clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt <= 17'h00000;
			ms_in_s <= 10'h000;
			flash_cnt <= 6'h00;
			flash <= 1'b0;
		end else begin
			if (ms_tick)
				tick_cnt <= 17'h00000;
			else
				tick_cnt <= tick_cnt + 17'h00001;
			if (sec_tick || state == lics_pkg::ST_INIT)
				ms_in_s <= 10'h000;
			else if (ms_tick && cycle_run)
				ms_in_s <= ms_in_s + 10'h001;
			if (ms_tick && flash_cnt == 6'(lics_pkg::FLASH_MS - 1)) begin
				flash_cnt <= 6'h00;
				flash <= ~flash;
			end else if (ms_tick) begin
				flash_cnt <= flash_cnt + 6'h01;
			end
		end
	end

	assign ms_tick = (tick_cnt == 17'(TICK_CYCLES - 1));
	// Seconds run only while charging so timeouts start at qualification
	assign cycle_run = (state == lics_pkg::ST_QUAL) ||
		(state == lics_pkg::ST_FAST);
	assign sec_tick = ms_tick && cycle_run &&
		(ms_in_s == 10'(lics_pkg::MS_PER_S - 1));

	//////////////////////////////////////////////////////////////////////////
	// Cycle timers, counting only in qualify and fast phases; blanking timer counting only in init
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ms <= 16'h0000;
			qual_s <= 16'h0000;
			total_s <= 16'h0000;
			low_ms <= 8'h00;
			blank_ms <= 16'h0000;
		end else begin
			if (state == lics_pkg::ST_INIT) begin
				phase_ms <= 16'h0000;
				qual_s <= 16'h0000;
				total_s <= 16'h0000;
				low_ms <= 8'h00;
			end else if (state == lics_pkg::ST_QUAL &&
				next_state == lics_pkg::ST_FAST) begin
				phase_ms <= 16'h0000;
			end else if (cycle_run && ms_tick) begin
				if (phase_ms != 16'hffff)
					phase_ms <= phase_ms + 16'h0001;
			end
			if (sec_tick && total_s != 16'hffff)
				total_s <= total_s + 16'h0001;
			if (sec_tick && qual_s != 16'hffff && state == lics_pkg::ST_QUAL)
				qual_s <= qual_s + 16'h0001;
			if (state == lics_pkg::ST_FAST && holdoff_done && cmp_q.below_end) begin
				if (ms_tick && !term_done)
					low_ms <= low_ms + 8'h01;
			end else if (state != lics_pkg::ST_PEND) begin
				low_ms <= 8'h00;
			end
			if (state != lics_pkg::ST_INIT)
				blank_ms <= 16'h0000;
			else if (ms_tick && !blank_done)
				blank_ms <= blank_ms + 16'h0001;
		end
	end

	assign holdoff_done = phase_ms >= 16'(lics_pkg::HOLDOFF_MS);
	assign term_done = low_ms >= 8'(lics_pkg::TERM_MS);
	assign blank_done = blank_ms >= 16'(lics_pkg::BLANK_MS);

	//////////////////////////////////////////////////////////////////////////
	// Charge state machine
	always_comb begin
		next_state = state;
		if (!pv_q) begin
			next_state = lics_pkg::ST_IDLE;
		end else begin
			case (state)
			lics_pkg::ST_IDLE: begin
				if (present)
					next_state = lics_pkg::ST_INIT;
				else
					next_state = lics_pkg::ST_FAULT;
			end
			lics_pkg::ST_INIT: begin
				if (lost)
					next_state = lics_pkg::ST_FAULT;
				else if (blank_done && !cmp_q.temp_ok)
					next_state = lics_pkg::ST_PEND;
				else if (blank_done)
					next_state = lics_pkg::ST_QUAL;
			end
			lics_pkg::ST_QUAL: begin
				if (lost)
					next_state = lics_pkg::ST_FAULT;
				else if (!cmp_q.temp_ok)
					next_state = lics_pkg::ST_PEND;
				else if (holdoff_done && cmp_q.above_floor)
					next_state = lics_pkg::ST_FAST;
				else if (qual_s >= qual_to_s)
					next_state = lics_pkg::ST_FAULT;
			end
			lics_pkg::ST_FAST: begin
				if (lost)
					next_state = lics_pkg::ST_FAULT;
				else if (!cmp_q.temp_ok)
					next_state = lics_pkg::ST_PEND;
				else if (total_s >= max_time_s || term_done)
					next_state = lics_pkg::ST_DONE;
			end
			lics_pkg::ST_DONE: begin
				if (lost)
					next_state = lics_pkg::ST_FAULT;
			end
			lics_pkg::ST_PEND: begin
				if (lost)
					next_state = lics_pkg::ST_FAULT;
				else if (cmp_q.temp_ok)
					next_state = ret_state;
			end
			lics_pkg::ST_FAULT: begin
				if (insert)
					next_state = lics_pkg::ST_INIT;
			end
			default: begin
				next_state = lics_pkg::ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= lics_pkg::ST_IDLE;
			ret_state <= lics_pkg::ST_QUAL;
		end else begin
			state <= next_state;
			if (next_state == lics_pkg::ST_PEND && state != lics_pkg::ST_PEND)
				ret_state <= (state == lics_pkg::ST_INIT) ? lics_pkg::ST_QUAL :
					state;
		end
	end

	// Configuration pins are latched at the end of the blanking window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			disp_mode <= lics_pkg::LVL_LOW;
			end_current_threshold <= lics_pkg::END_DIV10;
			cv_phase <= 1'b0;
		end else begin
			if (state == lics_pkg::ST_INIT && blank_done) begin
				disp_mode <= decode_level(display_choice);
				case (decode_level(end_current_select))
				lics_pkg::LVL_LOW: end_current_threshold <= lics_pkg::END_DIV10;
				lics_pkg::LVL_HIGH: end_current_threshold <= lics_pkg::END_DIV20;
				default: end_current_threshold <= lics_pkg::END_DIV30;
				endcase
			end
			if (state == lics_pkg::ST_INIT)
				cv_phase <= 1'b0;
			else if (state == lics_pkg::ST_FAST && cmp_q.at_target)
				cv_phase <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Regulation and switch modulation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_cnt <= '0;
			switch_drive <= 1'b0;
			reg_mode <= lics_pkg::REG_OFF;
		end else begin
			pwm_cnt <= pwm_cnt + 1'b1;
			switch_drive <= (next_state == lics_pkg::ST_QUAL ||
				next_state == lics_pkg::ST_FAST) &&
				(pwm_cnt < regulation_demand);
			case (next_state)
			lics_pkg::ST_QUAL: reg_mode <= lics_pkg::REG_COND;
			lics_pkg::ST_FAST: reg_mode <= (cv_phase || cmp_q.at_target) ?
				lics_pkg::REG_CV : lics_pkg::REG_CC;
			default: reg_mode <= lics_pkg::REG_OFF;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Indicators and inrush guard
	always_comb begin
		next_led = 3'b000;
		case (next_state)
		lics_pkg::ST_QUAL: begin
			case (disp_mode)
			lics_pkg::LVL_LOW: next_led = {2'b00, flash};
			lics_pkg::LVL_HIGH: next_led = 3'b011;
			default: next_led = {1'b0, flash, flash};
			endcase
		end
		lics_pkg::ST_FAST: begin
			case (disp_mode)
			lics_pkg::LVL_LOW: next_led = 3'b001;
			lics_pkg::LVL_HIGH: next_led = 3'b010;
			default: next_led = cv_phase ? 3'b011 : 3'b010;
			endcase
		end
		lics_pkg::ST_DONE: begin
			next_led = (disp_mode == lics_pkg::LVL_LOW) ? 3'b010 : 3'b001;
		end
		lics_pkg::ST_PEND: begin
			next_led = {flash, led_o[1:0]};
		end
		lics_pkg::ST_FAULT: begin
			next_led = present ? {1'b1, led_o[1:0]} : 3'b100;
		end
		default: begin
			next_led = 3'b000;
		end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_o <= 3'b000;
			led_oe <= 3'b000;
			indicator_common_o <= 1'b0;
			indicator_common_oe <= 1'b0;
			inrush_guard_n <= 1'b1;
		end else begin
			led_o <= next_led;
			led_oe <= (next_state == lics_pkg::ST_INIT) ? 3'b000 :
				3'b111;
			indicator_common_oe <= next_state != lics_pkg::ST_INIT;
			indicator_common_o <= 1'b0;
			inrush_guard_n <= !(next_state == lics_pkg::ST_FAULT ||
				next_state == lics_pkg::ST_DONE);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	chk_inrush_state: assert property (@(posedge hclk) disable iff (!hresetn)
		inrush_guard_n == !(state == lics_pkg::ST_FAULT ||
		state == lics_pkg::ST_DONE))
		else $error("inrush guard disagrees with state");
	chk_init_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
		state == lics_pkg::ST_INIT |-> led_oe == 3'b000 &&
		!indicator_common_oe)
		else $error("indicators driven during init");
	chk_term_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(state == lics_pkg::ST_FAST ##1 state == lics_pkg::ST_DONE) |->
		$past(low_ms) >= 8'(lics_pkg::TERM_MS) || $past(total_s >= max_time_s))
		else $error("terminated without low current or time");
	chk_pend_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		(state == lics_pkg::ST_PEND ##1 state == lics_pkg::ST_PEND) |->
		$stable(total_s) && $stable(phase_ms) && $stable(low_ms))
		else $error("timers moved in pending");
	chk_holdoff_mask: assert property (@(posedge hclk) disable iff (!hresetn)
		state == lics_pkg::ST_FAST && !holdoff_done && pv_q &&
		total_s < max_time_s |=> state != lics_pkg::ST_DONE)
		else $error("termination during holdoff");
	chk_drive_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!(state == lics_pkg::ST_QUAL || state == lics_pkg::ST_FAST) |->
		!switch_drive)
		else $error("switch drive outside charging");
	chk_absent_led: assert property (@(posedge hclk) disable iff (!hresetn)
		state == lics_pkg::ST_FAULT && next_state == lics_pkg::ST_FAULT &&
		!present |=> led_o == 3'b100)
		else $error("absent fault not shown");
	chk_qual_exit: assert property (@(posedge hclk) disable iff (!hresetn)
		(state == lics_pkg::ST_QUAL ##1 state == lics_pkg::ST_FAST) |->
		$past(cmp_q.above_floor && holdoff_done))
		else $error("fast charge before floor reached");
	chk_fault_exit: assert property (@(posedge hclk) disable iff (!hresetn)
		(state == lics_pkg::ST_FAULT ##1 state != lics_pkg::ST_FAULT) |->
		state == lics_pkg::ST_INIT || state == lics_pkg::ST_IDLE)
		else $error("fault left without restart");
	chk_temp_first: assert property (@(posedge hclk) disable iff (!hresetn)
		(state == lics_pkg::ST_INIT ##1 state == lics_pkg::ST_PEND) |->
		$past(!cmp_q.temp_ok) && ret_state == lics_pkg::ST_QUAL)
		else $error("pending entered with valid temperature");
endmodule

// ### rtl/lics_pkg.sv
// Package of constants and types for the charge sequencer
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Inrush guard output low in Fault or Charge Complete, high otherwise.
// - Common indicator output tristated during initialization to sense pin.
// - All three indicator outputs tristated during initialization.
// - Switch drive high passes current, low blocks it, pulse-width modulated.
// - End current select decoded as low, high or floating.
// - Display choice decoded as three levels picking indicator encoding.
// - Fast charge regulates constant current, then constant voltage at target.
// - Terminate after current stays below end threshold for 120 ms.
// - Start cycle on power valid with battery present, or on insertion.
// - Check temperature first; out of range enters Charge Pending.
// - Charge Pending flashes the third indicator.
// - Temperature watched all cycle, but ignored while in Fault or Charge Complete.
// - Pending freezes cycle timers and resumes at the interrupted point.
// - Qualification regulates conditioning current of one fifth full current.
// - After holdoff, reach floor before qualify timeout, else Fault.
// - Fault held until power cycles or insertion, then fresh cycle.
// - Overvoltage and absence alike enter Fault and light third indicator.
// - Maximum charge time from setting ends charging as backup.
// - Latch display choice on power, Fault exit, insertion; blank 750 ms.
// - End select low, high, float give thresholds full/10, /20, /30.
// - First 1.33 s of qualify and fast ignore cutoff and end current.
// - Voltage entering window is insertion, leaving it removal into Fault.
//////////////////////////////////////////////////////////////////////////////
package lics_pkg;
	// Register map, byte addresses
	localparam logic [7:0] CONFIG_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam int MAX_TIME_LSB = 0;
	localparam int QUAL_TO_LSB = 16;
	localparam logic [15:0] MAX_TIME_RESET = 16'h1c20;
	localparam logic [15:0] QUAL_TO_RESET = 16'h0708;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_MODE_LSB = 7;
	localparam int STAT_ENDSEL_LSB = 9;
	localparam int STAT_CV_LSB = 11;
	localparam int STAT_PRESENT_LSB = 12;

	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int MS_PER_S = 1000;
	localparam int HOLDOFF_MS = 1330;
	localparam int TERM_MS = 120;
	localparam int BLANK_MS = 750;
	localparam int FLASH_MS = 62;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_INIT = 7'h02,
		ST_QUAL = 7'h04,
		ST_FAST = 7'h08,
		ST_DONE = 7'h10,
		ST_PEND = 7'h20,
		ST_FAULT = 7'h40
	} lics_state_e;

	typedef enum logic [1:0] {
		REG_OFF = 2'h0,
		REG_COND = 2'h1,
		REG_CC = 2'h2,
		REG_CV = 2'h3
	} lics_reg_e;

	// Three-level pin decode: low, high, floating
	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_HIGH = 2'h1,
		LVL_FLOAT = 2'h2
	} lics_level_e;

	// End current threshold codes for the current comparator
	typedef enum logic [1:0] {
		END_DIV10 = 2'h0,
		END_DIV20 = 2'h1,
		END_DIV30 = 2'h2
	} lics_end_e;

	typedef struct packed {
		logic temp_ok;
		logic above_low;
		logic above_high;
		logic above_floor;
		logic at_target;
		logic below_end;
	} lics_cmp_s;

	typedef struct packed {
		logic seen_high;
		logic seen_low;
	} lics_tri_s;
endpackage

// ### verif/lics_pack_model.sv
// Behavioural battery pack, current sense and shared display pin
module lics_pack_model #(
	parameter int FULL_MA = 1000, // Full charge current
	parameter int TARGET_MV = 4200, // Target cell voltage
	parameter int FLOOR_MV = 3000 // Qualify voltage floor
) (
	input wire logic [15:0] pack_mv, // Cell voltage
	input wire logic [15:0] charge_ma, // Charge current
	input wire logic thermal_ok, // Temperature in range
	input wire logic [1:0] disp_pull, // 0 down, 1 up, 2 none
	input wire logic [1:0] endsel_pull, // 0 down, 1 up, 2 none
	input wire logic [2:0] led_o, // Indicator levels
	input wire logic [2:0] led_oe, // Indicator enables
	input wire lics_pkg::lics_end_e end_current_threshold, // Level code
	output lics_pkg::lics_cmp_s cmp, // Comparator results
	output lics_pkg::lics_tri_s end_current_select, // Sensed select pin
	output lics_pkg::lics_tri_s display_choice // Sensed display pin
);
	int div;

	always_comb begin
		case (end_current_threshold)
			lics_pkg::END_DIV10: div = 10;
			lics_pkg::END_DIV20: div = 20;
			default: div = 30;
		endcase
		cmp.temp_ok = thermal_ok;
		cmp.above_low = pack_mv > 800;
		cmp.above_high = pack_mv > TARGET_MV + 250;
		cmp.above_floor = pack_mv >= FLOOR_MV;
		cmp.at_target = pack_mv >= TARGET_MV;
		cmp.below_end = charge_ma * div < FULL_MA;
		end_current_select = '{endsel_pull == 2'h1, endsel_pull == 2'h0};
		// A driven indicator overrides the pull on the shared pin
		if (led_oe[1])
			display_choice = '{led_o[1], !led_o[1]};
		else
			display_choice = '{disp_pull == 2'h1, disp_pull == 2'h0};
	end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the charge sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	logic hclk, hresetn, hsel, hwrite, power_valid, thermal_ok;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, disp_pull, endsel_pull;
	logic [2:0] hsize, led_o, led_oe;
	logic hreadyout, hresp, switch_drive, inrush_guard_n;
	logic indicator_common_o, indicator_common_oe;
	logic [7:0] regulation_demand;
	logic [15:0] pack_mv, charge_ma;
	lics_pkg::lics_cmp_s cmp;
	lics_pkg::lics_tri_s end_current_select, display_choice;
	lics_pkg::lics_reg_e reg_mode;
	lics_pkg::lics_end_e end_current_threshold;
	int n_errors, checks;

	lics_charge_seq #(.TICK_CYCLES(TK)) dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .power_valid,
		.cmp, .end_current_select, .display_choice, .regulation_demand,
		.switch_drive, .reg_mode, .end_current_threshold, .inrush_guard_n,
		.led_o, .led_oe, .indicator_common_o, .indicator_common_oe
	);

	lics_pack_model pack (
		.pack_mv, .charge_ma, .thermal_ok, .disp_pull, .endsel_pull,
		.led_o, .led_oe, .end_current_threshold, .cmp,
		.end_current_select, .display_choice
	);

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got,
				exp);
		end
	endtask

	task automatic wait_ready;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (i >= 20) begin
			chk(0, 1, "bus hang");
			close_out;
		end
	endtask

	// One single-word transfer; returns with outputs settled
	task automatic bus(input logic wr, input logic [31:0] a, wd,
		output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_ready;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready;
		d = hrdata;
		#1;
	endtask

	// Polls the status word until the state shows up
	task automatic wait_state(input logic [6:0] s, input int ms);
		for (int i = 0; i <= ms * TK / 2; i++) begin
			bus(1'b0, 32'h4, 32'h0, rd);
			if (rd[6:0] === s)
				break;
		end
		chk(rd[6:0], s, "state");
		if (rd[6:0] !== s)
			close_out;
	endtask

	task automatic wait_ms(input int ms);
		repeat (ms * TK) @(posedge hclk);
		#1;
	endtask

	task automatic pwm(input logic [31:0] exp);
		logic [31:0] n;
		n = 0;
		repeat (256) begin
			@(posedge hclk);
			#1;
			n = n + switch_drive;
		end
		chk(n, exp, "pwm");
	endtask

	task automatic flash;
		logic [31:0] n;
		logic last;
		n = 0;
		last = led_o[2];
		repeat (250 * TK) begin
			@(posedge hclk);
			#1;
			if (led_o[2] !== last)
				n++;
			last = led_o[2];
		end
		chk(n >= 3 && n <= 5, 1, "flash");
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_bus;
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(rd, {lics_pkg::QUAL_TO_RESET, lics_pkg::MAX_TIME_RESET},
			"config");
		bus(1'b1, 32'h4, 32'hffffffff, rd);
		bus(1'b1, 32'h40, 32'h12345678, rd);
		bus(1'b0, 32'h40, 32'h0, rd);
		chk(rd, 32'h0, "unmapped");
		chk(hresp, 1'b0, "resp");
		wait_state(7'h01, 0);
		chk(inrush_guard_n, 1'b1, "inrush");
	endtask

	task automatic t_init_qual;
		power_valid <= 1'b1;
		wait_state(7'h02, 1);
		chk(led_oe, 3'h0, "led oe");
		chk(indicator_common_oe, 1'b0, "com oe");
		wait_ms(700);
		wait_state(7'h02, 0);
		wait_state(7'h04, 100);
		chk(rd[8:7], 2'h1, "mode");
		chk(led_oe, 3'h7, "led oe");
		chk(indicator_common_oe, 1'b1, "com oe");
		chk(indicator_common_o, 1'b0, "com");
		chk(reg_mode, lics_pkg::REG_COND, "cond");
		chk(end_current_threshold, lics_pkg::END_DIV10, "end");
		chk(led_o, 3'h3, "leds");
		pwm(64);
	endtask

	task automatic t_fast_pend;
		wait_ms(1050);
		wait_state(7'h04, 0);
		wait_state(7'h08, 500);
		chk(reg_mode, lics_pkg::REG_CC, "cc");
		chk(led_o, 3'h2, "leds");
		thermal_ok <= 1'b0;
		wait_state(7'h20, 5);
		chk(inrush_guard_n, 1'b1, "inrush");
		flash;
		thermal_ok <= 1'b1;
		wait_state(7'h08, 5);
		chk(reg_mode, lics_pkg::REG_CC, "cc");
		pack_mv <= 16'd4200;
		wait_ms(1);
		chk(reg_mode, lics_pkg::REG_CV, "cv");
		wait_state(7'h08, 0);
		chk(rd[11], 1'b1, "cv flag");
	endtask

	task automatic t_term;
		charge_ma <= 16'd60;
		wait_ms(1000);
		wait_state(7'h08, 0);
		charge_ma <= 16'd1000;
		wait_ms(500);
		charge_ma <= 16'd60;
		wait_ms(70);
		charge_ma <= 16'd150;
		wait_ms(20);
		wait_state(7'h08, 0);
		charge_ma <= 16'd60;
		wait_ms(75);
		wait_state(7'h08, 0);
		wait_state(7'h10, 100);
		chk(inrush_guard_n, 1'b0, "inrush");
		chk(led_o, 3'h1, "leds");
		pwm(0);
		chk(reg_mode, lics_pkg::REG_OFF, "off");
	endtask

	task automatic t_removal;
		pack_mv <= 16'd0;
		wait_state(7'h40, 5);
		chk(rd[12], 1'b0, "present");
		chk(inrush_guard_n, 1'b0, "inrush");
		chk(led_o, 3'h4, "leds");
		thermal_ok <= 1'b0;
		wait_ms(5);
		wait_state(7'h40, 0);
	endtask

	task automatic t_qual_timeout;
		bus(1'b1, 32'h0, 32'h00020003, rd);
		disp_pull <= 2'h0;
		endsel_pull <= 2'h1;
		pack_mv <= 16'd2500;
		wait_state(7'h02, 5);
		wait_state(7'h20, 800);
		chk(rd[8:7], 2'h0, "mode");
		chk(end_current_threshold, lics_pkg::END_DIV20, "end");
		thermal_ok <= 1'b1;
		wait_state(7'h04, 5);
		wait_ms(1900);
		wait_state(7'h04, 0);
		wait_state(7'h40, 300);
		chk(led_o[2], 1'b1, "led3");
		chk(inrush_guard_n, 1'b0, "inrush");
	endtask

	task automatic t_max_time;
		bus(1'b1, 32'h0, 32'h00030002, rd);
		power_valid <= 1'b0;
		wait_state(7'h01, 5);
		chk(inrush_guard_n, 1'b1, "inrush");
		disp_pull <= 2'h2;
		endsel_pull <= 2'h2;
		pack_mv <= 16'd3600;
		charge_ma <= 16'd1000;
		power_valid <= 1'b1;
		wait_state(7'h02, 5);
		wait_state(7'h04, 800);
		wait_state(7'h08, 1600);
		chk(rd[8:7], 2'h2, "mode");
		chk(end_current_threshold, lics_pkg::END_DIV30, "end");
		chk(led_o, 3'h2, "leds");
		wait_ms(500);
		wait_state(7'h08, 0);
		wait_state(7'h10, 400);
		chk(led_o, 3'h1, "leds");
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		n_errors = 0;
		checks = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		power_valid = 1'b0;
		regulation_demand = 8'h40;
		pack_mv = 16'd3600;
		charge_ma = 16'd1000;
		thermal_ok = 1'b1;
		disp_pull = 2'h1;
		endsel_pull = 2'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_bus;
		t_init_qual;
		t_fast_pend;
		t_term;
		t_removal;
		t_qual_timeout;
		t_max_time;
		close_out;
	end
endmodule
